// ---- src/exec_pkg.sv ----
package exec_pkg;
    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int PC_W_DEF = 12;
    localparam int STACK_DEPTH_DEF = 8;
    localparam int WDT_W_DEF = 8;
    localparam int PRESCALE_W_DEF = 4;
    localparam int INSTR_CYCLE_CLKS = 3;
    localparam logic [1:0] DUMMY_LAST = 2'(INSTR_CYCLE_CLKS - 1);
    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int CLASS_LSB = 12;
    localparam int SUB_LSB = 8;
    localparam int BIT_LSB = 8;
    localparam int M_LSB = 0;
    localparam logic [3:0] CLS_REG = 4'h0;
    localparam logic [3:0] CLS_BITCLR = 4'h1;
    localparam logic [3:0] CLS_CALL = 4'h2;
    localparam logic [3:0] CLS_JMP = 4'h3;
    localparam logic [3:0] SUB_NOP = 4'h0;
    localparam logic [3:0] SUB_ZERO_FILL = 4'h1;
    localparam logic [3:0] SUB_INVERT = 4'h2;
    localparam logic [3:0] SUB_INVERT_W = 4'h3;
    localparam logic [3:0] SUB_BCD_ADJUST = 4'h4;
    localparam logic [3:0] SUB_SUB_ONE = 4'h5;
    localparam logic [3:0] SUB_SUB_ONE_W = 4'h6;
    localparam logic [3:0] SUB_ADD_ONE = 4'h7;
    localparam logic [3:0] SUB_ADD_ONE_W = 4'h8;
    localparam logic [3:0] SUB_COPY_M_W = 4'h9;
    localparam logic [3:0] SUB_COPY_IMM = 4'ha;
    localparam logic [3:0] SUB_COPY_W_M = 4'hb;
    localparam logic [3:0] SUB_WDT_CLEAR = 4'hc;
    localparam logic [3:0] SUB_POWER_DOWN = 4'hd;
    // ------------------------------------------------------------
    // data values and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ZERO_FILL_VALUE = 8'h00;
    localparam logic [7:0] BIT_ONE = 8'h01;
    localparam logic [3:0] BCD_NIB_LIMIT = 4'h9;
    localparam logic [3:0] BCD_NIB_FIX = 4'h6;
    localparam logic [3:0] BCD_NIB_NONE = 4'h0;
    localparam logic [7:0] WREG_RST = 8'h00;
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_FETCH = 5'b00001,
        ST_READ = 5'b00010,
        ST_EXEC = 5'b00100,
        ST_DUMMY = 5'b01000,
        ST_SLEEP = 5'b10000
    } exec_state_t;
endpackage

// ---- src/stack_if.sv ----
`timescale 1ns/1ps
interface stack_if #(parameter int W = 12);
    logic push;
    logic [W-1:0] wdata;
    logic [W-1:0] top;
    modport core (output push, output wdata, input top);
    modport mem (input push, input wdata, output top);
endinterface

// ---- src/call_stack.sv ----
`timescale 1ns/1ps
module call_stack
    import exec_pkg::*;
#(
    parameter int W = PC_W_DEF,
    parameter int DEPTH = STACK_DEPTH_DEF
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // core side
    stack_if.mem bus
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PTR_W-1:0] ptr;
        logic [W-1:0] top;
    } stack_state_t;
    stack_state_t stack_reg;
    stack_state_t stack_next;

    // overflow wraps and overwrites the oldest entry, as a fixed-depth stack does
    always_comb begin
        stack_next = stack_reg;
        if (bus.push) begin
            stack_next.mem[stack_reg.ptr] = bus.wdata;
            stack_next.ptr = (stack_reg.ptr == PTR_W'(DEPTH - 1)) ? '0 : stack_reg.ptr + 1'b1;
            stack_next.top = bus.wdata;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stack_reg <= '0;
        end else begin
            stack_reg <= stack_next;
        end
    end

    assign bus.top = stack_reg.top;

    push_lands_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        bus.push |=> bus.top == $past(bus.wdata))
        else $error("pushed address not on top of stack");
endmodule // call_stack

// ---- src/instr_exec_core.sv ----
`timescale 1ns/1ps
module instr_exec_core
    import exec_pkg::*;
#(
    parameter int PC_W = PC_W_DEF,
    parameter int STACK_DEPTH = STACK_DEPTH_DEF,
    parameter int WDT_W = WDT_W_DEF,
    parameter int PRESCALE_W = PRESCALE_W_DEF
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // program memory
    output logic [PC_W-1:0] prog_addr_o,
    input wire logic [15:0] instr_i,
    // data memory
    output logic [7:0] dm_addr_o,
    output logic dm_re_o,
    input wire logic [7:0] dm_rdata_i,
    output logic dm_we_o,
    output logic [7:0] dm_wdata_o,
    // flag load from the rest of the core
    input wire logic status_load_i,
    input wire logic zero_in_i,
    input wire logic carry_in_i,
    input wire logic half_outflow_in_i,
    // wake pin
    input wire logic wake_i,
    // core state
    output logic [7:0] working_register_o,
    output logic zero_flag_o,
    output logic carry_flag_o,
    output logic half_outflow_flag_o,
    output logic watchdog_expired_flag_o,
    output logic sleep_entered_flag_o,
    output logic [WDT_W-1:0] watchdog_counter_o,
    output logic clock_run_o,
    output logic retire_o,
    output logic [PC_W-1:0] stack_top_o
);
    typedef struct packed {
        exec_state_t st;
        logic [1:0] phase;
        logic [PC_W-1:0] pc;
        logic [15:0] instr;
        logic [7:0] wreg;
        logic zf;
        logic cf;
        logic acf;
        logic tof;
        logic sleep_entered_flag;
        logic [WDT_W-1:0] wdt;
        logic [PRESCALE_W-1:0] pre;
        logic [7:0] dm_addr;
        logic [7:0] dm_wdata;
        logic dm_re;
        logic dm_we;
        logic run;
        logic retire;
        logic [2:0] wake_sync;
        logic push;
        logic [PC_W-1:0] push_data;
    } core_state_t;

    core_state_t r;
    core_state_t n;

    // ------------------------------------------------------------
    // decode of the latched word, and of the incoming word for the read strobe
    // ------------------------------------------------------------
    logic [3:0] cls;
    logic [3:0] sub;
    logic [2:0] bitpos;
    logic [PC_W-1:0] jump_addr;
    logic [PC_W-1:0] pc_plus1;
    logic in_read;
    logic op_call, op_jmp, op_bitclr, op_clr, op_cpl, op_invert_to_working_op, op_daa;
    logic op_dec, op_subtract_one_to_working_op, op_inc, op_add_one_to_working_op, op_movam, op_movax, op_movma;
    logic op_clrwdt, op_halt, two_cycle;
    assign cls = r.instr[CLASS_LSB +: 4];
    assign sub = r.instr[SUB_LSB +: 4];
    assign bitpos = r.instr[BIT_LSB +: 3];
    assign jump_addr = r.instr[PC_W-1:0];
    assign pc_plus1 = PC_W'(r.pc + 1'b1);
    assign in_read = (r.st == ST_READ);
    assign op_call = (cls == CLS_CALL);
    assign op_jmp = (cls == CLS_JMP);
    assign op_bitclr = (cls == CLS_BITCLR);
    assign op_clr = (cls == CLS_REG) && (sub == SUB_ZERO_FILL);
    assign op_cpl = (cls == CLS_REG) && (sub == SUB_INVERT);
    assign op_invert_to_working_op = (cls == CLS_REG) && (sub == SUB_INVERT_W);
    assign op_daa = (cls == CLS_REG) && (sub == SUB_BCD_ADJUST);
    assign op_dec = (cls == CLS_REG) && (sub == SUB_SUB_ONE);
    assign op_subtract_one_to_working_op = (cls == CLS_REG) && (sub == SUB_SUB_ONE_W);
    assign op_inc = (cls == CLS_REG) && (sub == SUB_ADD_ONE);
    assign op_add_one_to_working_op = (cls == CLS_REG) && (sub == SUB_ADD_ONE_W);
    assign op_movam = (cls == CLS_REG) && (sub == SUB_COPY_M_W);
    assign op_movax = (cls == CLS_REG) && (sub == SUB_COPY_IMM);
    assign op_movma = (cls == CLS_REG) && (sub == SUB_COPY_W_M);
    assign op_clrwdt = (cls == CLS_REG) && (sub == SUB_WDT_CLEAR);
    assign op_halt = (cls == CLS_REG) && (sub == SUB_POWER_DOWN);
    assign two_cycle = op_call || op_jmp;

    // only ops that consume the location strobe a read
    logic fetch_reads;
    logic [3:0] fcls;
    logic [3:0] fsub;
    assign fcls = instr_i[CLASS_LSB +: 4];
    assign fsub = instr_i[SUB_LSB +: 4];
    assign fetch_reads = (fcls == CLS_BITCLR) || ((fcls == CLS_REG) &&
        (fsub inside {SUB_INVERT, SUB_INVERT_W, SUB_SUB_ONE, SUB_SUB_ONE_W,
                      SUB_ADD_ONE, SUB_ADD_ONE_W, SUB_COPY_M_W}));

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    logic [7:0] bit_mask;
    logic [7:0] inv_val;
    logic [7:0] dec_val;
    logic [7:0] inc_val;
    logic lo_adj;
    logic hi_adj;
    logic [7:0] corr;
    logic [8:0] daa_sum;
    assign bit_mask = ~(BIT_ONE << bitpos);
    assign inv_val = ~dm_rdata_i;
    assign dec_val = dm_rdata_i - BIT_ONE;
    assign inc_val = dm_rdata_i + BIT_ONE;
    assign lo_adj = (r.wreg[3:0] > BCD_NIB_LIMIT) || r.acf;
    assign hi_adj = (r.wreg[7:4] > BCD_NIB_LIMIT) || r.cf;
    assign corr = {hi_adj ? BCD_NIB_FIX : BCD_NIB_NONE, lo_adj ? BCD_NIB_FIX : BCD_NIB_NONE};
    assign daa_sum = {1'b0, r.wreg} + {1'b0, corr};

    // watchdog runs only while the clock runs
    logic wdt_tick;
    logic wdt_expire;
    assign wdt_tick = (r.st != ST_SLEEP) && (&r.pre);
    assign wdt_expire = wdt_tick && (&r.wdt);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.push = 1'b0;
        n.dm_re = 1'b0;
        n.dm_we = 1'b0;
        n.retire = 1'b0;
        n.wake_sync = {r.wake_sync[1:0], wake_i};
        if (r.st != ST_SLEEP) begin
            n.pre = r.pre + 1'b1;
        end
        if (wdt_tick) begin
            n.wdt = r.wdt + 1'b1;
        end
        if (status_load_i) begin
            n.zf = zero_in_i;
            n.cf = carry_in_i;
            n.acf = half_outflow_in_i;
        end
        case (r.st)
            ST_FETCH: begin
                n.instr = instr_i;
                n.dm_addr = instr_i[M_LSB +: 8];
                n.dm_re = fetch_reads;
                n.st = ST_READ;
            end
            ST_READ: begin
                n.st = ST_EXEC;
                n.retire = !two_cycle;
                n.pc = pc_plus1;
                if (op_call) begin
                    n.push = 1'b1;
                    n.push_data = pc_plus1;
                    n.pc = jump_addr;
                end else if (op_jmp) begin
                    n.pc = jump_addr;
                end else if (op_bitclr) begin
                    n.dm_we = 1'b1;
                    n.dm_wdata = dm_rdata_i & bit_mask;
                end else if (op_clr) begin
                    n.dm_we = 1'b1;
                    n.dm_wdata = ZERO_FILL_VALUE;
                end else if (op_cpl || op_invert_to_working_op) begin
                    n.dm_we = op_cpl;
                    n.dm_wdata = inv_val;
                    if (op_invert_to_working_op) begin
                        n.wreg = inv_val;
                    end
                    n.zf = (inv_val == ZERO_FILL_VALUE);
                end else if (op_daa) begin
                    n.dm_we = 1'b1;
                    n.dm_wdata = daa_sum[7:0];
                    n.cf = r.cf | daa_sum[8];
                end else if (op_dec || op_subtract_one_to_working_op) begin
                    n.dm_we = op_dec;
                    n.dm_wdata = dec_val;
                    if (op_subtract_one_to_working_op) begin
                        n.wreg = dec_val;
                    end
                    n.zf = (dec_val == ZERO_FILL_VALUE);
                end else if (op_inc || op_add_one_to_working_op) begin
                    n.dm_we = op_inc;
                    n.dm_wdata = inc_val;
                    if (op_add_one_to_working_op) begin
                        n.wreg = inc_val;
                    end
                    n.zf = (inc_val == ZERO_FILL_VALUE);
                end else if (op_movam) begin
                    n.wreg = dm_rdata_i;
                end else if (op_movax) begin
                    n.wreg = r.instr[M_LSB +: 8];
                end else if (op_movma) begin
                    n.dm_we = 1'b1;
                    n.dm_wdata = r.wreg;
                end else if (op_clrwdt) begin
                    n.wdt = '0;
                    n.pre = '0;
                    n.tof = 1'b0;
                    n.sleep_entered_flag = 1'b0;
                end else if (op_halt) begin
                    n.wdt = '0;
                    n.pre = '0;
                    n.tof = 1'b0;
                    n.sleep_entered_flag = 1'b1;
                end
            end
            ST_EXEC: begin
                n.phase = '0;
                if (two_cycle) begin
                    n.st = ST_DUMMY;
                end else if (op_halt) begin
                    n.st = ST_SLEEP;
                    n.run = 1'b0;
                end else begin
                    n.st = ST_FETCH;
                end
            end
            ST_DUMMY: begin
                n.phase = r.phase + 1'b1;
                n.retire = (r.phase == DUMMY_LAST - 2'd1);
                if (r.phase == DUMMY_LAST) begin
                    n.st = ST_FETCH;
                end
            end
            ST_SLEEP: begin
                // wake only once the two late sync stages are both high
                if (r.wake_sync[1] && r.wake_sync[2]) begin
                    n.st = ST_FETCH;
                    n.run = 1'b1;
                end
            end
            default: begin
                n.st = ST_FETCH;
            end
        endcase
        // an expiry in the same cycle as a clear still lands
        if (wdt_expire) begin
            n.tof = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.st <= ST_FETCH;
            r.wreg <= WREG_RST;
            r.run <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // stack and outputs
    // ------------------------------------------------------------
    stack_if #(.W(PC_W)) stk ();
    assign stk.push = r.push;
    assign stk.wdata = r.push_data;
    call_stack #(.W(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .bus(stk.mem)
    );

    assign prog_addr_o = r.pc;
    assign dm_addr_o = r.dm_addr;
    assign dm_re_o = r.dm_re;
    assign dm_we_o = r.dm_we;
    assign dm_wdata_o = r.dm_wdata;
    assign working_register_o = r.wreg;
    assign zero_flag_o = r.zf;
    assign carry_flag_o = r.cf;
    assign half_outflow_flag_o = r.acf;
    assign watchdog_expired_flag_o = r.tof;
    assign sleep_entered_flag_o = r.sleep_entered_flag;
    assign watchdog_counter_o = r.wdt;
    assign clock_run_o = r.run;
    assign retire_o = r.retire;
    assign stack_top_o = stk.top;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i || status_load_i);

    call_push_a: assert property (in_read && op_call |=> stk.push &&
        stk.wdata == $past(pc_plus1) && r.pc == $past(jump_addr) && !retire_o
        ##3 retire_o) else $error("call push or target wrong");
    zero_fill_a: assert property (in_read && op_clr |=> dm_we_o &&
        dm_wdata_o == ZERO_FILL_VALUE && $stable({r.zf, r.cf, r.acf}))
        else $error("zero fill wrong");
    bit_clear_a: assert property (in_read && op_bitclr |=> dm_we_o &&
        dm_wdata_o == ($past(dm_rdata_i) & $past(bit_mask))) else $error("bit clear wrong");
    wdt_clear_a: assert property (in_read && op_clrwdt && !wdt_expire |=>
        r.wdt == '0 && !r.tof && !r.sleep_entered_flag) else $error("watchdog clear wrong");
    invert_mem_a: assert property (in_read && op_cpl |=> dm_we_o &&
        dm_wdata_o == ~$past(dm_rdata_i) && r.zf == (dm_wdata_o == ZERO_FILL_VALUE))
        else $error("invert wrong");
    invert_work_a: assert property (in_read && op_invert_to_working_op |=> !dm_we_o &&
        r.wreg == ~$past(dm_rdata_i)) else $error("invert to working wrong");
    bcd_nibble_a: assert property (in_read && op_daa && r.wreg[3:0] > BCD_NIB_LIMIT
        |-> corr[3:0] == BCD_NIB_FIX) else $error("low nibble not adjusted");
    bcd_result_a: assert property (in_read && op_daa |->
        corr inside {8'h00, 8'h06, 8'h60, 8'h66} ##1 (dm_we_o &&
        dm_wdata_o == $past(daa_sum[7:0]) && $stable({r.zf, r.acf})))
        else $error("bcd adjust wrong");
    sub_one_a: assert property (in_read && (op_dec || op_subtract_one_to_working_op) |=>
        (dm_we_o == $past(op_dec)) && r.zf == ($past(dec_val) == ZERO_FILL_VALUE) &&
        $stable({r.cf, r.acf})) else $error("decrement wrong");
    add_one_a: assert property (in_read && op_add_one_to_working_op |=> !dm_we_o &&
        r.wreg == $past(dm_rdata_i) + BIT_ONE) else $error("increment wrong");
    sleep_hold_a: assert property (r.st == ST_SLEEP && $past(r.st) == ST_SLEEP |->
        !clock_run_o && $stable(r.wreg) && $stable(r.pc) && !dm_we_o)
        else $error("state moved in sleep");
    power_down_a: assert property (in_read && op_halt && !wdt_expire |=>
        r.sleep_entered_flag && !r.tof && r.wdt == '0 ##1 r.st == ST_SLEEP)
        else $error("power down wrong");
    branch_a: assert property (in_read && op_jmp |=> r.pc == $past(jump_addr) &&
        !stk.push ##1 r.st == ST_DUMMY) else $error("branch wrong");
    copy_in_a: assert property (in_read && op_movam |=> r.wreg == $past(dm_rdata_i) &&
        $stable({r.zf, r.cf, r.acf})) else $error("copy to working wrong");
    copy_imm_a: assert property (in_read && op_movax |=>
        r.wreg == $past(r.instr[7:0])) else $error("copy immediate wrong");
    copy_out_a: assert property (in_read && op_movma |=> dm_we_o &&
        dm_wdata_o == $past(r.wreg)) else $error("copy to memory wrong");
    one_cycle_a: assert property (in_read && !two_cycle |=> retire_o ##1
        (r.st == ST_FETCH || r.st == ST_SLEEP)) else $error("single cycle op slow");

    call_seen_c: cover property (in_read && op_call);
    daa_both_c: cover property (in_read && op_daa && corr == 8'h66);
    sleep_wake_c: cover property (in_read && op_halt ##[2:40] r.st == ST_FETCH);
    wdt_expire_c: cover property (wdt_expire);
endmodule // instr_exec_core

// ---- sim/mem_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// program and data memory partner
// ----------------------------------------
module mem_model (
    // clock
    input wire logic sys_clk_i,
    // program side
    input wire logic [11:0] paddr_i,
    output logic [15:0] instr_o,
    // data side
    input wire logic [7:0] addr_i,
    input wire logic re_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [15:0] prog [0:4095];
    logic [7:0] dmem [0:255];
    logic [7:0] last_reg = 8'h00;
    assign instr_o = prog[paddr_i];
    // idle bus shows inverse of last read, so stale data never passes
    assign rdata_o = re_i ? dmem[addr_i] : ~last_reg;
    always @(posedge sys_clk_i) begin
        if (re_i) last_reg <= dmem[addr_i];
        if (we_i) dmem[addr_i] <= wdata_i;
    end
endmodule // mem_model

// ---- sim/mcu_instruction_execute_subset_tb.sv ----
`timescale 1ns/1ps
module mcu_instruction_execute_subset_tb;
    import exec_pkg::*;
    typedef struct packed {
        logic [15:0] ins;
        logic [7:0] pre, w, m;
        logic z, c;
    } row_t;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, wake_i = 1'b0, status_load_i = 1'b0;
    logic zero_in_i = 1'b0, carry_in_i = 1'b0, half_outflow_in_i = 1'b0;
    logic [11:0] prog_addr_o, stack_top_o;
    logic [15:0] instr_i;
    logic [7:0] dm_addr_o, dm_rdata_i, dm_wdata_o, working_register_o, watchdog_counter_o;
    logic dm_re_o, dm_we_o, zero_flag_o, carry_flag_o, half_outflow_flag_o, retire_o;
    logic watchdog_expired_flag_o, sleep_entered_flag_o, clock_run_o;
    logic saw_re = 1'b0;
    int err_total = 0, n_compared = 0, n;
    row_t rows [13] = '{
        '{16'h0a5a, 8'h00, 8'h5a, 8'h00, 1'b0, 1'b0}, '{16'h0b10, 8'h00, 8'h5a, 8'h5a, 1'b0, 1'b0},
        '{16'h0111, 8'hff, 8'h5a, 8'h00, 1'b0, 1'b0}, '{16'h1312, 8'hff, 8'h5a, 8'hf7, 1'b0, 1'b0},
        '{16'h0213, 8'hff, 8'h5a, 8'h00, 1'b1, 1'b0}, '{16'h0314, 8'h0f, 8'hf0, 8'h0f, 1'b0, 1'b0},
        '{16'h0515, 8'h01, 8'hf0, 8'h00, 1'b1, 1'b0}, '{16'h0616, 8'h00, 8'hff, 8'h00, 1'b0, 1'b0},
        '{16'h0717, 8'hff, 8'hff, 8'h00, 1'b1, 1'b0}, '{16'h0919, 8'h3c, 8'h3c, 8'h3c, 1'b1, 1'b0},
        '{16'h0818, 8'h41, 8'h42, 8'h41, 1'b0, 1'b0}, '{16'h0aa5, 8'h00, 8'ha5, 8'h00, 1'b0, 1'b0},
        '{16'h041a, 8'h00, 8'ha5, 8'h05, 1'b0, 1'b1}};
    always #25 sys_clk_i = ~sys_clk_i;
    instr_exec_core dut (.sys_clk_i, .resetn_i, .prog_addr_o, .instr_i, .dm_addr_o, .dm_re_o,
        .dm_rdata_i, .dm_we_o, .dm_wdata_o, .status_load_i, .zero_in_i, .carry_in_i,
        .half_outflow_in_i, .wake_i, .working_register_o, .zero_flag_o, .carry_flag_o,
        .half_outflow_flag_o, .watchdog_expired_flag_o, .sleep_entered_flag_o,
        .watchdog_counter_o, .clock_run_o, .retire_o, .stack_top_o);
    mem_model pm (.sys_clk_i(sys_clk_i), .paddr_i(prog_addr_o), .instr_o(instr_i),
        .addr_i(dm_addr_o), .re_i(dm_re_o), .we_i(dm_we_o), .wdata_i(dm_wdata_o),
        .rdata_o(dm_rdata_i));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic bad(input string what);
        err_total++;
        $display("unexpected at %0t: %s", $time, what);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) bad($sformatf("byte %h want %h", got, exp));
    endtask
    task automatic chkpc(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) bad($sformatf("address %h want %h", got, exp));
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) bad($sformatf("flag %b want %b", got, exp));
    endtask
    task automatic chkn(input int got, input int exp);
        n_compared++;
        if (got != exp) bad($sformatf("cycles %0d want %0d", got, exp));
    endtask
    // bounded wait for the end of one instruction, counting clocks
    task automatic run(output int k);
        k = 0;
        saw_re = 1'b0;
        do begin
            @(negedge sys_clk_i);
            k++;
            if (dm_re_o === 1'b1) saw_re = 1'b1;
        end while (retire_o !== 1'b1 && k < 40);
        if (retire_o !== 1'b1) bad("no retire");
    endtask
    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // whole run is under a hundred clocks; this span leaves wide margin
    initial begin
        #200000;
        bad("watchdog");
        conclude();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        foreach (pm.prog[i]) pm.prog[i] = 16'h0000;
        foreach (rows[i]) pm.prog[i] = rows[i].ins;
        foreach (rows[i]) pm.dmem[rows[i].ins[7:0]] = rows[i].pre;
        pm.prog[14] = 16'h0a00;
        pm.prog[15] = 16'h041b;
        pm.prog[16] = 16'h2040;
        pm.prog[12'h040] = 16'h3050;
        pm.prog[12'h050] = 16'h0d00;
        pm.prog[12'h051] = 16'h0c00;
        repeat (3) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        for (int i = 0; i < 13; i++) begin
            run(n);
            // first count starts mid-fetch, right after reset release
            chkn(n, (i == 0) ? 2 : 3);
            chk8(working_register_o, rows[i].w);
            chk8(dm_addr_o, rows[i].ins[7:0]);
            // rows 3 to 10 consume the location, the others must not strobe a read
            chk1(saw_re, i inside {[3:10]});
            chk1(dm_we_o, rows[i].m != rows[i].pre);
            if (rows[i].m != rows[i].pre) chk8(dm_wdata_o, rows[i].m);
            chk1(zero_flag_o, rows[i].z);
            chk1(carry_flag_o, rows[i].c);
        end
        status_load_i = 1'b1;
        carry_in_i = 1'b1;
        half_outflow_in_i = 1'b1;
        run(n);
        status_load_i = 1'b0;
        run(n);
        chk1(half_outflow_flag_o, 1'b1);
        run(n);
        chk8(dm_wdata_o, 8'h66);
        chk1(carry_flag_o, 1'b1);
        run(n);
        chkn(n, 6);
        chkpc(prog_addr_o, 12'h040);
        chkpc(stack_top_o, 12'h011);
        run(n);
        chkn(n, 6);
        chkpc(prog_addr_o, 12'h050);
        chk1(half_outflow_flag_o, 1'b1);
        run(n);
        chk1(sleep_entered_flag_o, 1'b1);
        chk1(watchdog_expired_flag_o, 1'b0);
        chk8(watchdog_counter_o, 8'h00);
        repeat (5) @(negedge sys_clk_i);
        chk1(clock_run_o, 1'b0);
        chk1(retire_o, 1'b0);
        chk8(pm.dmem[8'h10], 8'h5a);
        wake_i = 1'b1;
        for (n = 0; n < 20 && clock_run_o !== 1'b1; n++) @(negedge sys_clk_i);
        wake_i = 1'b0;
        chk1(clock_run_o, 1'b1);
        chkpc(prog_addr_o, 12'h051);
        chk8(working_register_o, 8'h00);
        run(n);
        chk1(sleep_entered_flag_o, 1'b0);
        chk1(watchdog_expired_flag_o, 1'b0);
        chk8(watchdog_counter_o, 8'h00);
        resetn_i = 1'b0;
        @(negedge sys_clk_i);
        chkpc(prog_addr_o, 12'h000);
        chk1(clock_run_o, 1'b1);
        conclude();
    end
endmodule // mcu_instruction_execute_subset_tb
